// File: src/ctrarr_regs.svh
// Purpose: Register offsets, field positions and reset values of the counter array
// Assumes: Plain register port with byte data
// Notes: Definitions only
`ifndef CTRARR_REGS_SVH
`define CTRARR_REGS_SVH
`define CA_ADDR_W 6
`define CA_OFF_CTRL 6'h00
`define CA_OFF_MODE 6'h01
`define CA_OFF_TLOW 6'h02
`define CA_OFF_THIGH 6'h03
`define CA_OFF_MASK 6'h04
`define CA_OFF_MODULE0 6'h08
`define CA_OFF_MODULE_STRIDE 6'h04
`define CA_MOD_MODE 2'h0
`define CA_MOD_CLOW 2'h1
`define CA_MOD_CHIGH 2'h2
`define CA_NUM_MODULES 5
`define CA_WDOG_MODULE 4
`define CA_BIT_IRQ 0
`define CA_BIT_PWM 1
`define CA_BIT_TOG 2
`define CA_BIT_MAT 3
`define CA_BIT_FALL 4
`define CA_BIT_RISE 5
`define CA_BIT_CMP 6
`define CA_BIT_RUN 6
`define CA_BIT_OVF 7
`define CA_BIT_OVF_IRQ 0
`define CA_BIT_WDOG 6
`define CA_SRC_LSB 1
`define CA_DIV_FAST 8'h06
`define CA_DIV_SLOW 8'h0c
`define CA_DIV2_FAST 8'h02
`define CA_DIV2_SLOW 8'h04
`define CA_RESET_BYTE 8'h00
`define CA_RESET_WORD 16'h0000
`endif

// File: src/ctrarr_pkg.sv
// Purpose: Types of the counter array
// Assumes: Nothing
// Notes: Source select codes
package ctrarr_pkg;
  typedef enum logic [1:0] {
    ctrarr_src_div6 = 2'h0,
    ctrarr_src_div2 = 2'h1,
    ctrarr_src_t0 = 2'h2,
    ctrarr_src_ext = 2'h3
  } ctrarr_src_t;
  typedef logic [7:0] ctrarr_byte_t;
endpackage

// File: src/ctrarr_top.sv
// Purpose: Five capture/compare modules on one 16-bit time base
// Assumes: Pins are asynchronous; timer-0 overflow comes from same clock
// Notes: Module 4 doubles as watchdog; its reset stays internal
// How it works
// RULE1 - Rise bit, fall bit or both choose capture edges; all clear does nothing.
// RULE2 - On a valid pin edge, copy the time base into the module's compare registers.
// RULE3 - Capture interrupts only when event flag and module interrupt enable are set.
// RULE4 - Compare plus match mode sets the event flag on equality, interrupting if enabled.
// RULE5 - Toggle plus match plus compare inverts the pin output on every match.
// RULE6 - PWM output low while timer low is below compare low, else high.
// RULE7 - In PWM, compare low reloads from compare high when timer low wraps.
// RULE8 - PWM only with PWM and compare set, capture, match, toggle clear.
// RULE9 - All modules share one time base, so PWM frequency is common.
// RULE10 - Only module 4 can be watchdog; otherwise it keeps every other mode.
// RULE11 - Watchdog enabled, a module 4 match raises an internal reset.
// RULE12 - Watchdog reset stays internal and never drives the external reset pin.
// RULE13 - Software puts module 4 in compare mode and sets enable; reset only then.
// RULE14 - Clearing watchdog enable before a match suppresses reset; setting re-arms it.
// RULE15 - Software moves module 4 compare ahead from the main program each wrap.
// RULE16 - Time base counts only while the run bit is set.
// RULE17 - Source select picks clock divided by 6 or 2, timer-0 overflow, or pin; with twelve_clock_mode set the code divides by 12 or 4.
// RULE18 - Overflow sets its flag and may interrupt; flags clear only by software.
// RULE19 - Each module pin is synchronised before edge detection.
`timescale 1ns/1ps
`include "ctrarr_regs.svh"
module ctrarr_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [`CA_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Count sources
  input wire logic twelve_clock_mode,
  input wire logic timer0_overflow,
  input wire logic external_count_input,
  // Module pins
  input wire logic [4:0] module_pin_in,
  output logic [4:0] module_pin_out,
  output logic [4:0] module_pin_oe_n,
  // Interrupt and internal reset
  output logic irq,
  output logic watchdog_reset
);
  import ctrarr_pkg::*;

  logic [7:0] ctrl;
  logic [7:0] mode_reg;
  logic [7:0] irq_mask;
  logic [7:0] timer_low;
  logic [7:0] timer_high;
  logic [7:0] mode [5];
  logic [7:0] compare_low [5];
  logic [7:0] compare_high [5];
  logic [2:0] pin_sync [5];
  logic [2:0] eci_sync;
  logic [4:0] pin_level;
  logic eci_level;
  logic [7:0] prescale;
  logic tick;
  logic [15:0] time_base;
  logic [4:0] match;
  logic [4:0] capture;
  logic [4:0] event_set;
  logic overflow;
  logic wrap_low;
  logic [4:0] is_pwm;
  logic [7:0] div_limit;
  ctrarr_src_t source;

  assign time_base = {timer_high, timer_low};
  assign source = ctrarr_src_t'(mode_reg[`CA_SRC_LSB +: 2]);

  // Pin and count input synchronisers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CA_NUM_MODULES; i++) begin
        pin_sync[i] <= 3'h0;
      end
      eci_sync <= 3'h0;
    end else begin
      for (int i = 0; i < `CA_NUM_MODULES; i++) begin
        pin_sync[i] <= {pin_sync[i][1:0], module_pin_in[i]}; // RULE19
      end
      eci_sync <= {eci_sync[1:0], external_count_input};
    end
  end

  // Settled levels: a change counts once the last two stages agree
  // One-stage glitches on a pad never reach the edge detectors
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_level <= 5'h00;
      eci_level <= 1'b0;
    end else begin
      for (int i = 0; i < `CA_NUM_MODULES; i++) begin
        if (pin_sync[i][1] == pin_sync[i][2]) begin
          pin_level[i] <= pin_sync[i][2]; // RULE19
        end
      end
      if (eci_sync[1] == eci_sync[2]) begin
        eci_level <= eci_sync[2];
      end
    end
  end

  // Count source prescaler
  always_comb begin
    if (source == ctrarr_src_div6) begin
      div_limit = twelve_clock_mode ? `CA_DIV_SLOW : `CA_DIV_FAST; // RULE17
    end else begin
      div_limit = twelve_clock_mode ? `CA_DIV2_SLOW : `CA_DIV2_FAST;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= `CA_RESET_BYTE;
    end else if (prescale >= div_limit - 8'h01) begin
      prescale <= `CA_RESET_BYTE;
    end else begin
      prescale <= prescale + 8'h01;
    end
  end

  always_comb begin
    case (source)
      ctrarr_src_div6: tick = prescale == div_limit - 8'h01; // RULE17
      ctrarr_src_div2: tick = prescale == div_limit - 8'h01;
      ctrarr_src_t0: tick = timer0_overflow;
      ctrarr_src_ext: tick = eci_sync[1] == eci_sync[2] && !eci_sync[2] && eci_level;
      default: tick = 1'b0;
    endcase
  end

  // Shared time base; each increment is one tick when running
  logic timer_wr;
  assign timer_wr = wr_en && (addr == `CA_OFF_TLOW || addr == `CA_OFF_THIGH);
  assign wrap_low = tick && ctrl[`CA_BIT_RUN] && timer_low == 8'hff;
  assign overflow = wrap_low && timer_high == 8'hff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_low <= `CA_RESET_BYTE;
      timer_high <= `CA_RESET_BYTE;
    end else if (timer_wr) begin
      if (addr == `CA_OFF_TLOW) begin
        timer_low <= wdata;
      end else begin
        timer_high <= wdata;
      end
    end else if (tick && ctrl[`CA_BIT_RUN]) begin
      {timer_high, timer_low} <= time_base + 16'h0001; // RULE16 RULE9
    end
  end

  // Per-module decode, matches and edges
  always_comb begin
    for (int i = 0; i < `CA_NUM_MODULES; i++) begin
      is_pwm[i] = mode[i][`CA_BIT_PWM] && mode[i][`CA_BIT_CMP] && !mode[i][`CA_BIT_RISE]
        && !mode[i][`CA_BIT_FALL] && !mode[i][`CA_BIT_MAT] && !mode[i][`CA_BIT_TOG]; // RULE8
      match[i] = tick && ctrl[`CA_BIT_RUN] && mode[i][`CA_BIT_CMP] && !is_pwm[i]
        && time_base == {compare_high[i], compare_low[i]}; // RULE4
      capture[i] = pin_sync[i][1] == pin_sync[i][2] && pin_sync[i][2] != pin_level[i]
        && (pin_sync[i][2] ? mode[i][`CA_BIT_RISE] : mode[i][`CA_BIT_FALL]); // RULE1
      event_set[i] = capture[i] || (match[i] && mode[i][`CA_BIT_MAT]); // RULE4
    end
  end

  // Mode and compare registers, capture and PWM reload
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CA_NUM_MODULES; i++) begin
        mode[i] <= `CA_RESET_BYTE;
        compare_low[i] <= `CA_RESET_BYTE;
        compare_high[i] <= `CA_RESET_BYTE;
      end
    end else begin
      for (int i = 0; i < `CA_NUM_MODULES; i++) begin
        if (wr_en && addr == `CA_OFF_MODULE0 + 6'(i) * `CA_OFF_MODULE_STRIDE) begin
          mode[i] <= {1'b0, wdata[6:0]};
        end
        // Capture beats software so the timestamp is never lost
        if (capture[i]) begin
          compare_low[i] <= timer_low; // RULE2
          compare_high[i] <= timer_high; // RULE2
        end else begin
          if (wr_en && addr == `CA_OFF_MODULE0 + 6'(i) * `CA_OFF_MODULE_STRIDE
              + 6'(`CA_MOD_CHIGH)) begin
            compare_high[i] <= wdata;
          end
          if (is_pwm[i] && wrap_low) begin
            compare_low[i] <= compare_high[i]; // RULE7
          end else if (wr_en && addr == `CA_OFF_MODULE0
              + 6'(i) * `CA_OFF_MODULE_STRIDE + 6'(`CA_MOD_CLOW)) begin
            compare_low[i] <= wdata;
          end
        end
      end
    end
  end

  // Pin outputs: toggle on match or PWM level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      module_pin_out <= 5'h1f;
      module_pin_oe_n <= 5'h1f;
    end else begin
      for (int i = 0; i < `CA_NUM_MODULES; i++) begin
        module_pin_oe_n[i] <= !(is_pwm[i] || (mode[i][`CA_BIT_TOG] && mode[i][`CA_BIT_MAT]
          && mode[i][`CA_BIT_CMP]));
        if (is_pwm[i]) begin
          module_pin_out[i] <= timer_low >= compare_low[i]; // RULE6
        end else if (match[i] && mode[i][`CA_BIT_TOG] && mode[i][`CA_BIT_MAT]) begin
          module_pin_out[i] <= !module_pin_out[i]; // RULE5
        end
      end
    end
  end

  // Control: run bit, sticky flags; set wins over clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CA_RESET_BYTE;
    end else begin
      if (wr_en && addr == `CA_OFF_CTRL) begin
        ctrl[`CA_BIT_RUN] <= wdata[`CA_BIT_RUN]; // RULE16
        ctrl[`CA_BIT_OVF] <= ctrl[`CA_BIT_OVF] & ~wdata[`CA_BIT_OVF];
        ctrl[4:0] <= ctrl[4:0] & ~wdata[4:0]; // RULE18
      end
      if (overflow) begin
        ctrl[`CA_BIT_OVF] <= 1'b1; // RULE18
      end
      for (int i = 0; i < `CA_NUM_MODULES; i++) begin
        if (event_set[i]) begin
          ctrl[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `CA_RESET_BYTE;
      irq_mask <= `CA_RESET_BYTE;
    end else begin
      if (wr_en && addr == `CA_OFF_MODE) begin
        mode_reg <= wdata;
      end
      if (wr_en && addr == `CA_OFF_MASK) begin
        irq_mask <= wdata;
      end
    end
  end

  // Interrupt: module flags gated by their own enables, overflow by its enable
  always_comb begin
    irq = ctrl[`CA_BIT_OVF] && mode_reg[`CA_BIT_OVF_IRQ] && irq_mask[`CA_BIT_OVF]; // RULE18
    for (int i = 0; i < `CA_NUM_MODULES; i++) begin
      if (ctrl[i] && mode[i][`CA_BIT_IRQ] && irq_mask[i]) begin
        irq = 1'b1; // RULE3
      end
    end
  end

  // Watchdog on module 4 only; internal pulse, no pin drive
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= mode_reg[`CA_BIT_WDOG] && match[`CA_WDOG_MODULE]
        && mode[`CA_WDOG_MODULE][`CA_BIT_MAT]; // RULE10 RULE11 RULE12 RULE13 RULE14
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `CA_RESET_BYTE;
    end else if (rd_en) begin
      rdata <= `CA_RESET_BYTE;
      case (addr)
        `CA_OFF_CTRL: rdata <= ctrl;
        `CA_OFF_MODE: rdata <= mode_reg;
        `CA_OFF_TLOW: rdata <= timer_low;
        `CA_OFF_THIGH: rdata <= timer_high;
        `CA_OFF_MASK: rdata <= irq_mask;
        default: begin
          for (int i = 0; i < `CA_NUM_MODULES; i++) begin
            if (addr == `CA_OFF_MODULE0 + 6'(i) * `CA_OFF_MODULE_STRIDE) begin
              rdata <= mode[i];
            end
            if (addr == `CA_OFF_MODULE0 + 6'(i) * `CA_OFF_MODULE_STRIDE + 6'h01) begin
              rdata <= compare_low[i];
            end
            if (addr == `CA_OFF_MODULE0 + 6'(i) * `CA_OFF_MODULE_STRIDE + 6'h02) begin
              rdata <= compare_high[i];
            end
          end
        end
      endcase
    end
  end
endmodule

// File: test/ctrarr_sva.sv
// Purpose: Port checks of the counter array
// Assumes: Register writes seen on the bus rebuild mask and mode shadows
// Notes: Module 2 is the watched mode register
`timescale 1ns/1ps
`include "ctrarr_regs.svh"
module ctrarr_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [`CA_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // Pins and events
  input wire logic [4:0] module_pin_oe_n,
  input wire logic irq,
  input wire logic watchdog_reset
);
  logic [7:0] mask, cmode, mode2;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `CA_RESET_BYTE;
      cmode <= `CA_RESET_BYTE;
      mode2 <= `CA_RESET_BYTE;
    end else if (wr_en) begin
      if (addr == `CA_OFF_MASK) mask <= wdata;
      if (addr == `CA_OFF_MODE) cmode <= wdata;
      if (addr == 6'h10) mode2 <= wdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_wdog_pulse: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog pulse too long");
  chk_wdog_gate: assert property (!cmode[6] && !$past(cmode[6]) |-> !watchdog_reset)
    else $error("watchdog reset while disabled");
  chk_irq_mask: assert property (mask == 8'h00 |-> !irq)
    else $error("irq with mask clear");
  chk_idle_oe: assert property (mode2 == 8'h00 && $past(mode2) == 8'h00 |-> module_pin_oe_n[2])
    else $error("idle module drives pin");
  chk_pwm_oe: assert property (mode2 == 8'h42 && $past(mode2) == 8'h42 |-> !module_pin_oe_n[2])
    else $error("pwm module not driving");
  chk_rdata_hold: assert property (!$past(rd_en) |-> $stable(rdata))
    else $error("read data moved without read");
  chk_unmapped_zero: assert property (rd_en && addr == 6'h3f |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mode_read: assert property (rd_en && addr == `CA_OFF_MODE |=> (rdata & 8'h47) == (cmode & 8'h47))
    else $error("count mode readback wrong");
  cover property (watchdog_reset);
  cover property (irq);
  cover property (!module_pin_oe_n[2]);
endmodule
bind ctrarr_top ctrarr_sva u_sva (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .module_pin_oe_n(module_pin_oe_n),
  .irq(irq), .watchdog_reset(watchdog_reset));

// File: test/ctrarr_pins.sv
// Purpose: Port pins facing the counter array
// Assumes: Count input idles high on its pull-up
// Notes: Pins move off the clock edge, as pads do
`timescale 1ns/1ps
module ctrarr_pins (
  // Clock
  input wire logic clock,
  // Requested levels
  input wire logic [4:0] level,
  input wire logic count_level,
  input wire logic t0_req,
  // Pins toward the block
  output logic [4:0] module_pin_in,
  output logic external_count_input,
  output logic timer0_overflow
);
  initial begin
    module_pin_in = 5'h00;
    external_count_input = 1'b1;
    timer0_overflow = 1'b0;
  end
  always @(posedge clock) module_pin_in <= #1 level;
  always @(posedge clock) external_count_input <= #1 count_level;
  always @(posedge clock) timer0_overflow <= #1 t0_req;
endmodule

// File: test/test_counter_array_modules.sv
// Purpose: Self-checking bench of the counter array
// Assumes: Timer stopped while values are loaded
// Notes: Every count source exercised, slow mode too
`timescale 1ns/1ps
`include "ctrarr_regs.svh"
module test_counter_array_modules;
  import ctrarr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  ctrarr_byte_t wdata = 8'h00;
  ctrarr_byte_t rdata;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [4:0] level = 5'h00;
  logic count_level = 1'b1;
  logic t0_req = 1'b0;
  logic slow = 1'b0;
  logic [4:0] pin_in, pin_out, oe_n;
  logic ext_in, t0_ovf, irq, wdog, p;
  int errors = 0;
  int comparisons = 0;
  int pulses = 0;
  always #2 clock = ~clock;
  always @(posedge clock) if (wdog === 1'b1) pulses++;
  ctrarr_pins u_pins (.clock(clock), .level(level), .count_level(count_level),
    .t0_req(t0_req), .module_pin_in(pin_in),
    .external_count_input(ext_in), .timer0_overflow(t0_ovf));
  ctrarr_top u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .twelve_clock_mode(slow),
    .timer0_overflow(t0_ovf), .external_count_input(ext_in), .module_pin_in(pin_in),
    .module_pin_out(pin_out), .module_pin_oe_n(oe_n), .irq(irq), .watchdog_reset(wdog));
  function automatic logic [5:0] ma(input int n, input int r);
    return 6'(`CA_OFF_MODULE0 + n * `CA_OFF_MODULE_STRIDE + r);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic cap(input logic [7:0] m, input logic l, input logic [7:0] t, e);
    wr(ma(0, `CA_MOD_MODE), m);
    wr(`CA_OFF_TLOW, t);
    level[0] <= l;
    repeat (6) @(posedge clock);
    rchk(ma(0, `CA_MOD_CLOW), e);
  endtask
  task automatic t_capture();
    rchk(`CA_OFF_CTRL, 8'h00);
    rchk(6'h3f, 8'h00);
    wr(`CA_OFF_THIGH, 8'h12);
    wr(`CA_OFF_MASK, 8'h01);
    cap(8'h21, 1'b1, 8'h34, 8'h34);
    rchk(ma(0, `CA_MOD_CHIGH), 8'h12);
    rchk(`CA_OFF_CTRL, 8'h01);
    chk({7'h00, irq}, 8'h01);
    cap(8'h21, 1'b0, 8'h56, 8'h34);
    cap(8'h31, 1'b1, 8'h78, 8'h78);
    cap(8'h11, 1'b0, 8'h9a, 8'h9a);
    wr(`CA_OFF_CTRL, 8'h01);
    #1 chk({7'h00, irq}, 8'h00);
  endtask
  task automatic t_match();
    wr(`CA_OFF_THIGH, 8'h00);
    wr(`CA_OFF_TLOW, 8'h10);
    wr(ma(1, `CA_MOD_CLOW), 8'h14);
    wr(ma(1, `CA_MOD_CHIGH), 8'h00);
    wr(ma(1, `CA_MOD_MODE), 8'h4c);
    wr(`CA_OFF_MODE, 8'h02);
    rchk(`CA_OFF_MODE, 8'h02);
    p = pin_out[1];
    wr(`CA_OFF_CTRL, 8'h40);
    repeat (20) @(posedge clock);
    wr(`CA_OFF_CTRL, 8'h00);
    #1 chk({7'h00, pin_out[1]}, {7'h00, ~p});
    rchk(`CA_OFF_CTRL, 8'h02);
  endtask
  task automatic t_pwm();
    wr(ma(2, `CA_MOD_CLOW), 8'h80);
    wr(ma(2, `CA_MOD_CHIGH), 8'h90);
    wr(ma(2, `CA_MOD_MODE), 8'h42);
    wr(`CA_OFF_TLOW, 8'h7f);
    repeat (3) @(posedge clock);
    #1 chk({7'h00, pin_out[2]}, 8'h00);
    wr(`CA_OFF_TLOW, 8'h80);
    repeat (3) @(posedge clock);
    #1 chk({7'h00, pin_out[2]}, 8'h01);
    wr(`CA_OFF_TLOW, 8'hff);
    wr(`CA_OFF_CTRL, 8'h40);
    repeat (4) @(posedge clock);
    wr(`CA_OFF_CTRL, 8'h00);
    rchk(ma(2, `CA_MOD_CLOW), 8'h90);
    chk({7'h00, pin_out[2]}, 8'h00);
  endtask
  task automatic t_wdog();
    wr(`CA_OFF_THIGH, 8'h00);
    wr(`CA_OFF_TLOW, 8'h20);
    wr(ma(4, `CA_MOD_CLOW), 8'h30);
    wr(ma(4, `CA_MOD_CHIGH), 8'h00);
    wr(ma(4, `CA_MOD_MODE), 8'h48);
    wr(`CA_OFF_CTRL, 8'h40);
    repeat (40) @(posedge clock);
    wr(`CA_OFF_CTRL, 8'h00);
    chk(8'(pulses), 8'h00);
    wr(`CA_OFF_TLOW, 8'h20);
    wr(`CA_OFF_MODE, 8'h42);
    wr(`CA_OFF_CTRL, 8'h40);
    repeat (40) @(posedge clock);
    wr(`CA_OFF_CTRL, 8'h00);
    chk(8'(pulses), 8'h01);
  endtask
  task automatic run_for(input int n);
    wr(`CA_OFF_CTRL, 8'h40);
    repeat (n) @(posedge clock);
    wr(`CA_OFF_CTRL, 8'h00);
  endtask
  task automatic t_sources();
    wr(`CA_OFF_CTRL, 8'h1f);
    wr(`CA_OFF_MASK, 8'h80);
    wr(`CA_OFF_MODE, 8'h03);
    wr(`CA_OFF_THIGH, 8'hff);
    wr(`CA_OFF_TLOW, 8'hfe);
    run_for(6);
    rchk(`CA_OFF_CTRL, 8'h80);
    chk({7'h00, irq}, 8'h01);
    rchk(`CA_OFF_THIGH, 8'h00);
    wr(`CA_OFF_CTRL, 8'h80);
    #1 chk({7'h00, irq}, 8'h00);
    wr(`CA_OFF_MODE, 8'h00);
    wr(`CA_OFF_TLOW, 8'h00);
    run_for(22);
    rchk(`CA_OFF_TLOW, 8'h04);
    slow <= 1'b1;
    wr(`CA_OFF_TLOW, 8'h00);
    run_for(22);
    rchk(`CA_OFF_TLOW, 8'h02);
    slow <= 1'b0;
    wr(`CA_OFF_MODE, 8'h04);
    wr(`CA_OFF_TLOW, 8'h00);
    wr(`CA_OFF_CTRL, 8'h40);
    repeat (3) begin
      t0_req <= 1'b1;
      @(posedge clock);
      t0_req <= 1'b0;
      repeat (3) @(posedge clock);
    end
    wr(`CA_OFF_CTRL, 8'h00);
    rchk(`CA_OFF_TLOW, 8'h03);
    wr(`CA_OFF_MODE, 8'h06);
    wr(`CA_OFF_TLOW, 8'h00);
    wr(`CA_OFF_CTRL, 8'h40);
    repeat (2) begin
      count_level <= 1'b0;
      repeat (6) @(posedge clock);
      count_level <= 1'b1;
      repeat (6) @(posedge clock);
    end
    wr(`CA_OFF_CTRL, 8'h00);
    rchk(`CA_OFF_TLOW, 8'h02);
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_capture();
    t_match();
    t_pwm();
    t_wdog();
    t_sources();
    conclude();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    conclude();
  end
endmodule
